/* rtl/arp_readout_top.sv */
`timescale 1ns/1ps
`include "arp_cfg.svh"
module arp_readout_top #(
	parameter int CH_NUM = `ARP_CH_NUM,
	parameter int RES_W = `ARP_RES_W
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// conversion core
	input wire logic convert_start_i,
	input wire logic conv_done_i,
	input wire logic [CH_NUM*RES_W-1:0] conv_result_i,
	output logic busy_o,
	// host strobes
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic sclk_i,
	// configuration
	input wire logic interface_select_i,
	input wire logic serial_b_only_i,
	// parallel data bus
	input wire logic [RES_W-1:0] data_i,
	output logic [RES_W-1:0] data_o,
	output logic [RES_W-1:0] data_oe_o,
	// serial outputs and flag
	output logic serial_out_a_o,
	output logic serial_out_a_oe_o,
	output logic serial_out_b_o,
	output logic serial_out_b_oe_o,
	output logic first_channel_flag_o,
	output logic first_channel_flag_oe_o
);
	localparam int IDX_W = $clog2(CH_NUM) + 1;
	localparam int SNAP_W = CH_NUM * RES_W;
	localparam int HALF_W = RES_W / 2;

	logic [`ARP_SY_W-1:0] sy_raw;
	logic [`ARP_SY_W-1:0] sy1_r;
	logic [`ARP_SY_W-1:0] sy2_r;
	logic start_s;
	logic cs_s;
	logic rd_s;
	logic isel_s;
	logic bsel_s;
	logic hbf_s;
	logic start_d_r;
	logic cs_d_r;
	logic rd_d_r;
	logic start_rise;
	logic cs_rise;
	logic rd_fall;
	logic [1:0] strap_cnt_r;
	logic strap_take;
	arp_pkg::arp_mode_t mode_r;
	arp_pkg::arp_mode_t mode_nxt;
	logic is_par;
	logic is_byte;
	logic is_ser;
	logic busy_r;
	logic load;
	logic clr_r;
	logic [SNAP_W-1:0] snap_r;
	logic [IDX_W-1:0] idx_r;
	logic [IDX_W-2:0] word_sel;
	logic [RES_W-1:0] cur_word;
	logic hi_pick;
	logic [HALF_W-1:0] byte_val;
	logic [RES_W-1:0] data_nxt;
	logic [RES_W-1:0] data_r;
	logic par_en;
	logic [RES_W-1:0] oe_nxt;
	logic [RES_W-1:0] data_oe_r;
	logic par_flag_r;
	logic ser_en;

	arp_ser_if #(.SNAP_W(SNAP_W)) sif ();

	// start, select, strobe, interface select and db14/db15 cross two flops; adds about 10 to 15 ns to the bus access time
	assign sy_raw = {data_i[`ARP_HBF_BIT], data_i[`ARP_BSEL_BIT], interface_select_i, rd_n_i, cs_n_i,
		convert_start_i};

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			sy1_r <= `ARP_SY_RST;
			sy2_r <= `ARP_SY_RST;
		end else begin
			sy1_r <= sy_raw;
			sy2_r <= sy1_r;
		end
	end

	assign start_s = sy2_r[`ARP_SY_START];
	assign cs_s = sy2_r[`ARP_SY_CS];
	assign rd_s = sy2_r[`ARP_SY_RD];
	assign isel_s = sy2_r[`ARP_SY_ISEL];
	assign bsel_s = sy2_r[`ARP_SY_BSEL];
	assign hbf_s = sy2_r[`ARP_SY_HBF];

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			start_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			rd_d_r <= 1'b1;
		end else begin
			start_d_r <= start_s;
			cs_d_r <= cs_s;
			rd_d_r <= rd_s;
		end
	end

	assign start_rise = start_s & ~start_d_r;
	assign cs_rise = cs_s & ~cs_d_r;
	// a joined select/strobe falls both at once, which counts as one strobe
	assign rd_fall = rd_d_r & ~rd_s & ~cs_s;

	// mode pins are straps: db15 is a bus line later, so take them once after reset while the bus floats
	assign strap_take = (strap_cnt_r == `ARP_STRAP_TAKE);
	assign mode_nxt = arp_pkg::arp_mode_t'({isel_s, bsel_s});

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			strap_cnt_r <= `ARP_STRAP_RST;
			mode_r <= arp_pkg::mode_bad;
		end else begin
			if (strap_cnt_r != `ARP_STRAP_DONE) begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
			end
			if (strap_take) begin
				mode_r <= mode_nxt;
			end
		end
	end

	assign is_par = (mode_r == arp_pkg::mode_par16);
	assign is_byte = (mode_r == arp_pkg::mode_byte);
	assign is_ser = (mode_r == arp_pkg::mode_serial);

	// result registers change only here, so reads during busy see the old set
	assign load = conv_done_i & busy_r;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			busy_r <= 1'b0;
		end else if (load) begin
			busy_r <= 1'b0;
		end else if (start_rise) begin
			busy_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			snap_r <= '0;
		end else if (load) begin
			snap_r <= conv_result_i;
		end
	end

	// clear pulse resets the link-side counters; the host is idle at the busy fall
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			clr_r <= 1'b1;
		end else begin
			clr_r <= load;
		end
	end

	// byte mode walks idx twice per channel; idx bit 0 picks the half
	assign word_sel = is_byte ? idx_r[IDX_W-1:1] : idx_r[IDX_W-2:0];
	assign cur_word = snap_r[word_sel * RES_W +: RES_W];
	assign hi_pick = hbf_s ^ idx_r[0];
	assign byte_val = hi_pick ? cur_word[RES_W-1:HALF_W] : cur_word[HALF_W-1:0];
	assign data_nxt = is_byte ? {{HALF_W{1'b0}}, byte_val} : cur_word;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			idx_r <= '0;
			data_r <= '0;
			par_flag_r <= 1'b0;
		end else if (load) begin
			idx_r <= '0;
			par_flag_r <= 1'b0;
		end else if (rd_fall) begin
			idx_r <= idx_r + IDX_W'(1);
			data_r <= data_nxt;
			par_flag_r <= (word_sel == '0);
		end
	end

	// enable follows the strobes one cycle late so it lines up with the data register
	assign par_en = (is_par | is_byte) & ~cs_s & ~rd_s;
	assign oe_nxt = is_byte ? {{HALF_W{1'b0}}, {HALF_W{par_en}}} : {RES_W{par_en}};

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			data_oe_r <= '0;
		end else begin
			data_oe_r <= oe_nxt;
		end
	end

	assign sif.clr = clr_r;
	// output a is the default single line since its order is ascending
	assign sif.b_only = serial_b_only_i;
	assign sif.snap = snap_r;

	arp_ser_shift #(
		.CH_NUM(CH_NUM),
		.RES_W(RES_W)
	) u_shift (
		.sclk_i(sclk_i),
		.sif(sif)
	);

	assign ser_en = is_ser & ~cs_s;
	assign busy_o = busy_r;
	assign data_o = data_r;
	assign data_oe_o = data_oe_r;
	assign serial_out_a_o = sif.dout_a;
	assign serial_out_b_o = sif.dout_b;
	assign serial_out_a_oe_o = ser_en;
	assign serial_out_b_oe_o = ser_en;
	assign first_channel_flag_o = is_ser ? sif.flag : par_flag_r;
	assign first_channel_flag_oe_o = ~cs_s & (is_ser | is_par | is_byte);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_conv_start;
		start_rise && !busy_r && !conv_done_i;
	endsequence
	sequence s_conv_end;
		load;
	endsequence
	sequence s_first_byte_hi;
		is_byte && rd_fall && !load && (idx_r == '0) && hbf_s;
	endsequence
	sequence s_first_byte_lo;
		is_byte && rd_fall && !load && (idx_r == '0) && !hbf_s;
	endsequence
	// a strobe while deselected must neither move the pointer nor drive the bus
	sequence s_strobe_no_cs;
		rd_d_r && !rd_s && cs_s && !load;
	endsequence

	busy_rise_a: assert property (s_conv_start |=> busy_r ##1 busy_r || $past(load))
		else $error("busy did not rise on conversion start");
	load_ptr_a: assert property (s_conv_end |=> !busy_r && (idx_r == '0) && (snap_r == $past(conv_result_i)))
		else $error("results or pointer not set on busy fall");
	prev_data_a: assert property ((busy_r && !load) |=> $stable(snap_r))
		else $error("results changed while busy");
	oe_gate_a: assert property ((|data_oe_o) |-> !$past(cs_s) && !$past(rd_s))
		else $error("bus driven without select and strobe");
	cs_rise_a: assert property (cs_rise |=> (data_oe_o == '0) ##1 (data_oe_o == '0))
		else $error("bus not released on select rise");
	rd_adv_a: assert property ((rd_fall && !load) |=> idx_r == $past(idx_r) + IDX_W'(1))
		else $error("read strobe did not advance channel");
	first_word_a: assert property ((is_par && rd_fall && !load && idx_r == '0) |=> data_r == snap_r[RES_W-1:0])
		else $error("first strobe did not present channel 1");
	byte_lane_a: assert property (is_byte |-> (data_r[RES_W-1:HALF_W] == '0) && (data_oe_o[RES_W-1:HALF_W] == '0))
		else $error("byte mode used upper lines");
	byte_order_a: assert property (s_first_byte_hi |=> data_r[HALF_W-1:0] == snap_r[RES_W-1:HALF_W])
		else $error("high byte not first");
	byte_flag_a: assert property ((is_byte && rd_fall && !load && idx_r == IDX_W'(1)) |=> par_flag_r)
		else $error("flag fell before second byte of channel 1");
	mode_a: assert property (strap_take |=> mode_r == arp_pkg::arp_mode_t'({$past(isel_s), $past(bsel_s)}))
		else $error("mode not taken from straps");
	ser_oe_a: assert property (is_ser |-> (serial_out_a_oe_o == !cs_s) && (serial_out_b_oe_o == !cs_s))
		else $error("serial enable does not follow select");

	// busy, flag and clear pulse around the busy fall; busy only drops at that edge
	busy_hold_a: assert property ((busy_r && !load) |=> busy_r)
		else $error("busy dropped without conversion end");
	clr_pulse_a: assert property (load |=> clr_r)
		else $error("link counters not cleared on busy fall");
	load_flag_a: assert property (load |=> !par_flag_r)
		else $error("first-channel flag not cleared on busy fall");

	// parallel bus gating and data hold
	no_cs_read_a: assert property (s_strobe_no_cs |=> $stable(idx_r) && (data_oe_o == '0))
		else $error("deselected strobe acted");
	oe_release_a: assert property ((cs_s || rd_s) |=> (data_oe_o == '0))
		else $error("bus still driven after select or strobe rose");
	word_lanes_a: assert property ((is_par && (|data_oe_o)) |-> (&data_oe_o))
		else $error("16-bit mode drove only part of the bus");
	bad_mode_a: assert property ((mode_r == arp_pkg::mode_bad) |->
		(data_oe_o == '0) && !first_channel_flag_oe_o)
		else $error("invalid mode drove a pin");
	data_hold_a: assert property (!rd_fall |=> $stable(data_r))
		else $error("bus data changed without a strobe");
	low_first_a: assert property (s_first_byte_lo |=> data_r[HALF_W-1:0] == snap_r[HALF_W-1:0])
		else $error("low byte not first");

	// channel 1 marking in both parallel modes
	par_flag_set_a: assert property ((is_par && rd_fall && !load && word_sel == '0) |=> par_flag_r)
		else $error("flag missing on channel 1 word");
	par_flag_drop_a: assert property ((is_par && rd_fall && !load && word_sel != '0) |=> !par_flag_r)
		else $error("flag high on a later channel");
	byte_flag_drop_a: assert property ((is_byte && rd_fall && !load && idx_r == IDX_W'(2)) |=> !par_flag_r)
		else $error("flag still high on channel 2");
endmodule : arp_readout_top

/* rtl/arp_cfg.svh */
`ifndef ARP_CFG_SVH
`define ARP_CFG_SVH
`define ARP_CH_NUM 8
`define ARP_RES_W 16
`define ARP_HBF_BIT 14
`define ARP_BSEL_BIT 15
`define ARP_SY_START 0
`define ARP_SY_CS 1
`define ARP_SY_RD 2
`define ARP_SY_ISEL 3
`define ARP_SY_BSEL 4
`define ARP_SY_HBF 5
`define ARP_SY_W 6
`define ARP_SY_RST 6'h06
`define ARP_STRAP_RST 2'h0
`define ARP_STRAP_TAKE 2'h2
`define ARP_STRAP_DONE 2'h3
`endif

/* rtl/arp_pkg.sv */
package arp_pkg;
	// code is {interface_select, byte_mode_select}
	typedef enum logic [1:0] {
		mode_par16 = 2'b00,
		mode_bad = 2'b01,
		mode_serial = 2'b10,
		mode_byte = 2'b11
	} arp_mode_t;
endpackage : arp_pkg

/* rtl/arp_ser_if.sv */
`timescale 1ns/1ps
`include "arp_cfg.svh"
interface arp_ser_if #(
	parameter int SNAP_W = `ARP_CH_NUM * `ARP_RES_W
);
	logic clr;
	logic b_only;
	logic [SNAP_W-1:0] snap;
	logic dout_a;
	logic dout_b;
	logic flag;
	modport core (output clr, output b_only, output snap, input dout_a, input dout_b, input flag);
	modport shift (input clr, input b_only, input snap, output dout_a, output dout_b, output flag);
endinterface : arp_ser_if

/* rtl/arp_ser_shift.sv */
`timescale 1ns/1ps
`include "arp_cfg.svh"
module arp_ser_shift #(
	parameter int CH_NUM = `ARP_CH_NUM,
	parameter int RES_W = `ARP_RES_W
) (
	// link clock
	input wire logic sclk_i,
	// core side
	arp_ser_if.shift sif
);
	localparam int CNT_W = $clog2(CH_NUM * RES_W);
	localparam int BIT_W = $clog2(RES_W);
	localparam int SLOT_W = CNT_W - BIT_W;

	logic [CNT_W-1:0] rise_cnt_r;
	logic [CNT_W-1:0] fall_cnt_r;
	logic [SLOT_W-1:0] slot_a;
	logic [SLOT_W-1:0] slot_b;
	logic [SLOT_W-1:0] fall_slot;
	logic [BIT_W-1:0] bit_idx;
	logic clr_seen_r;

	// counters survive chip select highs so per-channel framing carries on; only reset or a new result clears them
	always_ff @(posedge sclk_i or posedge sif.clr) begin
		if (sif.clr) begin
			rise_cnt_r <= '0;
		end else begin
			rise_cnt_r <= rise_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(negedge sclk_i or posedge sif.clr) begin
		if (sif.clr) begin
			fall_cnt_r <= '0;
		end else begin
			fall_cnt_r <= fall_cnt_r + CNT_W'(1);
		end
	end

	// marks the first rise of a fresh readout: a host may stop after 64 bits, so slots need not wrap
	always_ff @(posedge sclk_i or posedge sif.clr) begin
		if (sif.clr) begin
			clr_seen_r <= 1'b1;
		end else begin
			clr_seen_r <= 1'b0;
		end
	end

	// serial clock idles high: each cycle is a fall (host samples) then a rise (next bit)
	assign slot_a = rise_cnt_r[CNT_W-1:BIT_W];
	assign slot_b = slot_a + SLOT_W'(CH_NUM / 2);
	assign bit_idx = BIT_W'(RES_W - 1) - rise_cnt_r[BIT_W-1:0];
	// mux from stable snapshot: the bit is ready before any sclk edge; the pin enable follows select only after its two-flop synchroniser
	assign sif.dout_a = sif.snap[slot_a * RES_W + int'(bit_idx)];
	assign sif.dout_b = sif.snap[slot_b * RES_W + int'(bit_idx)];
	assign fall_slot = fall_cnt_r[CNT_W-1:BIT_W];
	assign sif.flag = sif.b_only ? (fall_slot == SLOT_W'(CH_NUM / 2)) : (fall_slot == '0);

	flag_drop_a: assert property (@(negedge sclk_i) disable iff (sif.clr)
		(!sif.b_only && fall_cnt_r == CNT_W'(RES_W - 1)) |=> !sif.flag)
		else $error("flag did not drop after the 16th fall");
	b_flag_a: assert property (@(negedge sclk_i) disable iff (sif.clr)
		(sif.b_only && fall_cnt_r == CNT_W'(CH_NUM / 2 * RES_W - 1)) |=> sif.flag ##1 sif.flag)
		else $error("flag missing when channel 1 reaches output b");
	msb_wrap_a: assert property (@(posedge sclk_i) disable iff (sif.clr)
		(rise_cnt_r[BIT_W-1:0] == BIT_W'(RES_W - 1)) |=> (bit_idx == BIT_W'(RES_W - 1)) &&
		(clr_seen_r ? (slot_a == '0) : (slot_a == $past(slot_a) + SLOT_W'(1))))
		else $error("serial word did not advance to next msb");
endmodule : arp_ser_shift

/* dv/arp_host_model.sv */
`timescale 1ns/1ps
module arp_host_model (
	// reference clock for strobe spacing
	input wire logic ref_clk_i,
	// what the host sees on the pins
	input wire logic [15:0] data_i,
	input wire logic [15:0] oe_i,
	input wire logic dout_a_i,
	input wire logic dout_b_i,
	input wire logic flag_i,
	// host strobes
	output logic cs_n_o,
	output logic rd_n_o,
	output logic sclk_o
);
	// sclk idles high and only toggles inside a frame
	initial begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		sclk_o = 1'b1;
	end
	// strobes held 6 cycles to cover the synchronisers; never issued at the load edge
	task automatic par_read(input logic sel, output logic [15:0] w, output logic [15:0] oe, output logic f);
		@(negedge ref_clk_i);
		cs_n_o = ~sel;
		rd_n_o = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		w = data_i;
		oe = oe_i;
		f = flag_i;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask : par_read
	// a frame may cover one channel or many; the odd offset keeps sclk off the ref edges
	task automatic ser_frame(input int n, input int base, inout logic [127:0] a, inout logic [127:0] b,
		inout logic [127:0] f);
		@(negedge ref_clk_i);
		cs_n_o = 1'b0;
		#21.3;
		for (int i = base; i < base + n; i++) begin
			a[i] = dout_a_i;
			b[i] = dout_b_i;
			f[i] = flag_i;
			sclk_o = 1'b0;
			#62.5;
			sclk_o = 1'b1;
			#62.5;
		end
		cs_n_o = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask : ser_frame
endmodule : arp_host_model

/* dv/arp_readout_top_bench.sv */
`timescale 1ns/1ps
module arp_readout_top_bench;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic convert_start_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic [127:0] conv_result_i = '0;
	logic interface_select_i = 1'b0;
	logic serial_b_only_i = 1'b0;
	logic strap = 1'b0;
	logic hbf = 1'b0;
	logic [15:0] bus_drv = '0;
	logic [127:0] cur = '0;
	integer seed = 32'h11A8;
	int bad_count = 0;
	int samples_checked = 0;
	logic busy_o, cs_n, rd_n, sclk, sa_o, sa_oe, sb_o, sb_oe, fl_o, fl_oe, f;
	logic [15:0] data_i, data_o, data_oe_o, w, oe;
	logic [127:0] a, b, fv, ea, eb, ef;
	// undriven serial and flag pins float so a missing enable never reads as a match
	wire sa = sa_oe ? sa_o : 1'bz;
	wire sb = sb_oe ? sb_o : 1'bz;
	wire fl = fl_oe ? fl_o : 1'bz;
	assign data_i = (data_oe_o & data_o) | (~data_oe_o & bus_drv);
	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(negedge ref_clk_i) bus_drv <= {strap, hbf, 14'($random(seed))};
	arp_readout_top u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .convert_start_i(convert_start_i),
		.conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .busy_o(busy_o), .cs_n_i(cs_n), .rd_n_i(rd_n),
		.sclk_i(sclk), .interface_select_i(interface_select_i), .serial_b_only_i(serial_b_only_i),
		.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .serial_out_a_o(sa_o),
		.serial_out_a_oe_o(sa_oe), .serial_out_b_o(sb_o), .serial_out_b_oe_o(sb_oe),
		.first_channel_flag_o(fl_o), .first_channel_flag_oe_o(fl_oe));
	arp_host_model u_host (.ref_clk_i(ref_clk_i), .data_i(data_i), .oe_i(data_oe_o), .dout_a_i(sa),
		.dout_b_i(sb), .flag_i(fl), .cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk));
	task automatic summarize();
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic boot(input logic isel, input logic bsel);
		@(negedge ref_clk_i);
		resetn_i = 1'b0;
		interface_select_i = isel;
		strap = bsel;
		repeat (5) @(negedge ref_clk_i);
		check({busy_o, data_oe_o, sa_oe, sb_oe, fl_oe}, 0);
		resetn_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask : boot
	task automatic start_conv();
		int n;
		for (int i = 0; i < 4; i++) conv_result_i[32*i +: 32] = $random(seed);
		convert_start_i = 1'b1;
		n = 0;
		while (busy_o !== 1'b1 && n < 8) begin
			@(negedge ref_clk_i);
			n++;
		end
		convert_start_i = 1'b0;
		check(n < 8, 1);
		if (n >= 8) summarize();
	endtask : start_conv
	task automatic end_conv();
		conv_done_i = 1'b1;
		@(negedge ref_clk_i);
		conv_done_i = 1'b0;
		cur = conv_result_i;
		check(busy_o, 0);
		repeat (2) @(negedge ref_clk_i);
	endtask : end_conv
	task automatic par_seq(input int k0, input int n, input bit bm);
		int c;
		for (int k = k0; k < k0 + n; k++) begin
			c = bm ? k / 2 : k % 8;
			u_host.par_read(1'b1, w, oe, f);
			if (bm) begin
				check({oe, w[7:0]}, {16'h00FF, cur[16*c + 8*((k % 2) ^ hbf) +: 8]});
			end else begin
				check({oe, w}, {16'hFFFF, cur[16*c +: 16]});
			end
			check(f, c == 0);
			check(data_oe_o, 0);
		end
	endtask : par_seq
	task automatic ser_exp();
		for (int i = 0; i < 128; i++) begin
			ea[i] = cur[16*(i/16) + 15 - i%16];
			eb[i] = cur[16*((i/16 + 4) % 8) + 15 - i%16];
			ef[i] = serial_b_only_i ? (i >= 64 && i < 80) : (i < 16);
		end
	endtask : ser_exp
	initial begin
		boot(1'b0, 1'b0);
		start_conv();
		end_conv();
		par_seq(0, 3, 0);
		// a strobe without chip select must leave the bus and the pointer alone
		u_host.par_read(1'b0, w, oe, f);
		check(oe, 0);
		start_conv();
		par_seq(3, 1, 0);
		end_conv();
		par_seq(0, 8, 0);
		hbf = 1'b1;
		boot(1'b1, 1'b1);
		start_conv();
		end_conv();
		par_seq(0, 16, 1);
		hbf = 1'b0;
		start_conv();
		end_conv();
		par_seq(0, 16, 1);
		boot(1'b1, 1'b0);
		start_conv();
		end_conv();
		ser_exp();
		for (int j = 0; j < 8; j++) u_host.ser_frame(16, 16*j, a, b, fv);
		check({a, fv}, {ea, ef});
		check({sa_oe, sb_oe, fl_oe}, 0);
		start_conv();
		end_conv();
		ser_exp();
		u_host.ser_frame(64, 0, a, b, fv);
		check({a[63:0], b[63:0]}, {ea[63:0], eb[63:0]});
		serial_b_only_i = 1'b1;
		start_conv();
		end_conv();
		ser_exp();
		u_host.ser_frame(128, 0, a, b, fv);
		check({b, fv}, {eb, ef});
		summarize();
	end
endmodule : arp_readout_top_bench
